// ---- nvsp_defines.svh ----
// Timing and width constants for the nonvolatile SRAM port host controller.
// Assumes a 10 MHz system clock; all counts are derived from printed times.
`ifndef NVSP_DEFINES_SVH
`define NVSP_DEFINES_SVH

// ==========================================================================
// Clock and bus geometry
// ==========================================================================
`define NVSP_CLK_PERIOD_NS   100
`define NVSP_ADDR_W          17
`define NVSP_DATA_W          16

// ==========================================================================
// Printed times in their own units
// ==========================================================================
`define NVSP_POWERUP_WAIT_MS        1
`define NVSP_SLEEP_EXIT_WAIT_US     500
`define NVSP_SLEEP_LOW_MIN_US       1
`define NVSP_PAGE_WRITE_CYCLE_MIN_NS 40
`define NVSP_PAGE_BITS_STABLE_NS    15
`define NVSP_ACCESS_NS              90
`define NVSP_PRECHARGE_NS           30
`define NVSP_WE_PULSE_NS            70

// ==========================================================================
// Derived cycle counts (least times round up, at least one cycle)
// ==========================================================================
`define NVSP_CEIL_CYC(ns) (((ns) + `NVSP_CLK_PERIOD_NS - 1) / `NVSP_CLK_PERIOD_NS)
`define NVSP_POWERUP_WAIT_CYC   (`NVSP_POWERUP_WAIT_MS * 1000000 / `NVSP_CLK_PERIOD_NS)
`define NVSP_SLEEP_EXIT_WAIT_CYC (`NVSP_SLEEP_EXIT_WAIT_US * 1000 / `NVSP_CLK_PERIOD_NS)
`define NVSP_SLEEP_LOW_MIN_CYC  (`NVSP_SLEEP_LOW_MIN_US * 1000 / `NVSP_CLK_PERIOD_NS)
`define NVSP_PAGE_WRITE_CYC     `NVSP_CEIL_CYC(`NVSP_PAGE_WRITE_CYCLE_MIN_NS)
`define NVSP_PAGE_STABLE_CYC    `NVSP_CEIL_CYC(`NVSP_PAGE_BITS_STABLE_NS)
`define NVSP_ACCESS_CYC         `NVSP_CEIL_CYC(`NVSP_ACCESS_NS)
`define NVSP_PRECHARGE_CYC      `NVSP_CEIL_CYC(`NVSP_PRECHARGE_NS)
`define NVSP_WE_PULSE_CYC       `NVSP_CEIL_CYC(`NVSP_WE_PULSE_NS)

`endif

// ---- nvsp_host_ctrl.sv ----
// Host controller driving an asynchronous nonvolatile 128K x 16 SRAM port.
// Assumes a 10 MHz clock; read data returns over the two-way data pins.
`timescale 1ns/1ps
`default_nettype none
`include "nvsp_defines.svh"

module nvsp_host_ctrl #(
  parameter int unsigned POWERUP_CYC    = `NVSP_POWERUP_WAIT_CYC,
  parameter int unsigned SLEEP_EXIT_CYC = `NVSP_SLEEP_EXIT_WAIT_CYC
) (
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  // User request side
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire nvsp_pkg::nvsp_addr_type req_addr_in,
  input  wire nvsp_pkg::nvsp_data_type req_wdata_in,
  input  wire logic [1:0]        req_lanes_in,
  input  wire logic              sleep_req_in,
  output logic                   req_ready_out,
  output logic                   rdata_valid_out,
  output nvsp_pkg::nvsp_data_type rdata_out,
  output logic                   asleep_out,
  // Memory pins
  output logic                   chip_enable_n_out,
  output logic                   write_enable_n_out,
  output logic                   output_enable_n_out,
  output logic                   upper_lane_select_n_out,
  output logic                   lower_lane_select_n_out,
  output logic                   sleep_request_n_out,
  output nvsp_pkg::nvsp_addr_type mem_addr_out,
  input  wire nvsp_pkg::nvsp_data_type mem_dq_in,
  output nvsp_pkg::nvsp_data_type mem_dq_out,
  output logic                   mem_dq_oe_out
);
  import nvsp_pkg::*;

  localparam int unsigned ROW_LSB = 2;

  typedef struct packed {
    nvsp_state_type state;
    logic           ce_n;
    logic           we_n;
    logic           oe_n;
    logic           ub_n;
    logic           lb_n;
    logic           zz_n;
    nvsp_addr_type  addr;
    nvsp_data_type  wdata;
    logic           dq_oe;
    logic           row_open;
    logic           rvalid;
    logic           pu_loaded;
    nvsp_data_type  rdata;
    nvsp_data_type  dq_s1;
    nvsp_data_type  dq_s2;
  } nvsp_ctrl_state_type;

  nvsp_ctrl_state_type cur;
  nvsp_ctrl_state_type next_cur;
  nvsp_timer_if        tmr ();
  logic                same_row;

  // ==========================================================================
  // Wait timer for every minimum time
  // ==========================================================================
  nvsp_wait_timer u_timer (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .tmr      (tmr.timer)
  );

  // Page access is legal only while chip enable stays low on the open row
  assign same_row = cur.row_open && !cur.ce_n &&
                    (req_addr_in[`NVSP_ADDR_W-1:ROW_LSB] == cur.addr[`NVSP_ADDR_W-1:ROW_LSB]);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    next_cur        = cur;
    next_cur.rvalid = 1'b0;
    next_cur.dq_s1  = mem_dq_in;      // Pins are asynchronous to our clock
    next_cur.dq_s2  = cur.dq_s1;
    tmr.load        = 1'b0;
    tmr.count       = 24'h000000;
    unique case (cur.state)
      NVSP_POWERUP: begin
        if (!cur.pu_loaded) begin
          // First cycle after reset starts the full wait; timer reads zero before
          next_cur.pu_loaded = 1'b1;
          tmr.load           = 1'b1;
          tmr.count          = 24'(POWERUP_CYC);
        end else if (tmr.expired) begin
          next_cur.state = NVSP_IDLE;
        end
      end
      NVSP_IDLE: begin
        if (sleep_req_in) begin
          // No gap needed after the last write; the row closes in the same cycle as sleep request falls
          next_cur.ce_n     = 1'b1;
          next_cur.oe_n     = 1'b1;
          next_cur.dq_oe    = 1'b0;
          next_cur.zz_n     = 1'b0;
          next_cur.row_open = 1'b0;
          next_cur.state    = NVSP_SLEEP;
          tmr.load          = 1'b1;
          tmr.count         = 24'(`NVSP_SLEEP_LOW_MIN_CYC);
        end else if (req_valid_in && !cur.ce_n && !same_row) begin
          // Leaving the row: raise chip enable and precharge
          next_cur.ce_n     = 1'b1;
          next_cur.oe_n     = 1'b1;
          next_cur.row_open = 1'b0;
          next_cur.state    = NVSP_PRECHG;
          tmr.load          = 1'b1;
          tmr.count         = 24'(`NVSP_PRECHARGE_CYC);
        end else if (req_valid_in) begin
          next_cur.addr     = req_addr_in;
          next_cur.ub_n     = ~req_lanes_in[1];
          next_cur.lb_n     = ~req_lanes_in[0];
          next_cur.ce_n     = 1'b0;
          next_cur.row_open = 1'b1;
          tmr.load          = 1'b1;
          if (req_write_in) begin
            // Write-enable write: write enable falls with chip enable, or under the held chip enable on a page write; no output enable
            next_cur.wdata = req_wdata_in;
            next_cur.oe_n  = 1'b1;
            next_cur.we_n  = 1'b0;
            next_cur.dq_oe = 1'b1;
            next_cur.state = NVSP_WR_PULSE;
            tmr.count      = same_row ? 24'(`NVSP_PAGE_WRITE_CYC)
                                      : 24'(`NVSP_WE_PULSE_CYC);
          end else begin
            next_cur.oe_n  = 1'b0;
            next_cur.state = NVSP_RD_ADDR;
            // Page read needs only the short page access time
            tmr.count      = same_row ? 24'(`NVSP_PAGE_STABLE_CYC)
                                      : 24'(`NVSP_ACCESS_CYC);
          end
        end
      end
      NVSP_RD_ADDR: begin
        // Two extra cycles cover the data synchroniser
        if (tmr.expired) begin
          next_cur.state = NVSP_RD_DONE;
          tmr.load       = 1'b1;
          tmr.count      = 24'h000002;
        end
      end
      NVSP_RD_DONE: begin
        if (tmr.expired) begin
          next_cur.rdata  = cur.dq_s2;
          next_cur.rvalid = 1'b1;
          next_cur.oe_n   = 1'b1;
          next_cur.state  = NVSP_IDLE;
        end
      end
      NVSP_WR_PULSE: begin
        if (tmr.expired) begin
          // Rising write enable latches data; chip enable stays low
          next_cur.we_n  = 1'b1;
          next_cur.state = NVSP_WR_GAP;
        end
      end
      NVSP_WR_GAP: begin
        // Hold data one cycle past the rising edge, then release
        next_cur.dq_oe = 1'b0;
        next_cur.state = NVSP_IDLE;
      end
      NVSP_PRECHG: begin
        if (tmr.expired) begin
          next_cur.state = NVSP_IDLE;
        end
      end
      NVSP_SLEEP: begin
        if (tmr.expired && !sleep_req_in) begin
          next_cur.zz_n  = 1'b1;
          next_cur.state = NVSP_WAKE;
          tmr.load       = 1'b1;
          tmr.count      = 24'(SLEEP_EXIT_CYC);
        end
      end
      NVSP_WAKE: begin
        if (tmr.expired) begin
          next_cur.state = NVSP_IDLE;
        end
      end
      default: begin
        next_cur.state = NVSP_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register; the power-up wait starts at reset release
  // ==========================================================================
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '{state: NVSP_POWERUP, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
               ub_n: 1'b1, lb_n: 1'b1, zz_n: 1'b1, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign req_ready_out           = (cur.state == NVSP_IDLE) && !sleep_req_in;
  assign rdata_valid_out         = cur.rvalid;
  assign rdata_out               = cur.rdata;
  assign asleep_out              = !cur.zz_n;
  assign chip_enable_n_out       = cur.ce_n;
  assign write_enable_n_out      = cur.we_n;
  assign output_enable_n_out     = cur.oe_n;
  assign upper_lane_select_n_out = cur.ub_n;
  assign lower_lane_select_n_out = cur.lb_n;
  assign sleep_request_n_out     = cur.zz_n;
  assign mem_addr_out            = cur.addr;
  assign mem_dq_out              = cur.wdata;
  assign mem_dq_oe_out           = cur.dq_oe;

endmodule : nvsp_host_ctrl

`default_nettype wire

// ---- nvsp_host_ctrl_assertions.sv ----
// Pin-level checks for the host controller, bound into nvsp_host_ctrl.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module nvsp_host_ctrl_assertions #(
  parameter int unsigned POWERUP_CYC    = 20,
  parameter int unsigned SLEEP_EXIT_CYC = 20
) (
  input wire logic                    clock_in,
  input wire logic                    rst_n_in,
  input wire logic                    sleep_req_in,
  input wire logic                    req_ready_out,
  input wire logic                    rdata_valid_out,
  input wire logic                    asleep_out,
  input wire logic                    chip_enable_n_out,
  input wire logic                    write_enable_n_out,
  input wire logic                    output_enable_n_out,
  input wire logic                    sleep_request_n_out,
  input wire nvsp_pkg::nvsp_addr_type mem_addr_out,
  input wire logic                    mem_dq_oe_out
);
  import nvsp_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // ====================
  // Wait counters, saturating so a long run never wraps
  logic [23:0] up_cnt;
  logic [23:0] wake_cnt;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_cnt   <= 24'h0;
      wake_cnt <= 24'hFFFFFF; // No sleep yet, so no wake wait owed
    end else begin
      up_cnt   <= (&up_cnt) ? up_cnt : up_cnt + 24'h1;
      wake_cnt <= !sleep_request_n_out ? 24'h0 : (&wake_cnt) ? wake_cnt : wake_cnt + 24'h1;
    end
  end

  // ====================
  // Assertions
  AST_POWERUP_WAIT : assert property (
    $fell(chip_enable_n_out) |-> up_cnt >= POWERUP_CYC) else $error("Access before power-up wait");
  AST_WAKE_WAIT : assert property (
    $fell(chip_enable_n_out) |-> wake_cnt >= SLEEP_EXIT_CYC) else $error("Access too soon after wake");
  AST_SLEEP_RELEASE : assert property (
    !sleep_request_n_out |-> !mem_dq_oe_out && asleep_out) else $error("Drive or flag wrong in sleep");
  AST_NO_CONTENTION : assert property (
    mem_dq_oe_out |-> output_enable_n_out) else $error("Host drives data while output enabled");
  AST_WRITE_UNDER_CE : assert property (
    !write_enable_n_out |-> !chip_enable_n_out) else $error("Write pulse without chip enable");
  AST_ROW_HELD : assert property (
    !write_enable_n_out && !$past(write_enable_n_out) |-> $stable(mem_addr_out))
    else $error("Address moved during write pulse");
  AST_PAGE_BITS_HOLD : assert property (
    $changed(mem_addr_out[1:0]) && !chip_enable_n_out |=> $stable(mem_addr_out[1:0]))
    else $error("Page word bits not held");
  AST_PRECHARGE : assert property (
    $rose(chip_enable_n_out) |=> chip_enable_n_out) else $error("Precharge cut short");
  AST_READY_GATED : assert property (
    req_ready_out |-> sleep_request_n_out && !sleep_req_in) else $error("Ready while sleeping");
  AST_RDATA_PULSE : assert property (
    rdata_valid_out |=> !rdata_valid_out) else $error("Read valid longer than one cycle");

  // Main scenarios reached
  COV_WRITE : cover property ($fell(write_enable_n_out));
  COV_READ : cover property (rdata_valid_out);
  COV_SLEEP : cover property ($fell(sleep_request_n_out));
  COV_PRECHARGE : cover property ($rose(chip_enable_n_out));
endmodule : nvsp_host_ctrl_assertions

bind nvsp_host_ctrl nvsp_host_ctrl_assertions #(.POWERUP_CYC(POWERUP_CYC),
  .SLEEP_EXIT_CYC(SLEEP_EXIT_CYC)) u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .sleep_req_in(sleep_req_in), .req_ready_out(req_ready_out),
  .rdata_valid_out(rdata_valid_out), .asleep_out(asleep_out),
  .chip_enable_n_out(chip_enable_n_out), .write_enable_n_out(write_enable_n_out),
  .output_enable_n_out(output_enable_n_out), .sleep_request_n_out(sleep_request_n_out),
  .mem_addr_out(mem_addr_out), .mem_dq_oe_out(mem_dq_oe_out));

`default_nettype wire

// ---- nvsp_pkg.sv ----
// Types shared by the host controller and its wait timer.
// Assumes nvsp_defines.svh is on the include path.
`include "nvsp_defines.svh"

package nvsp_pkg;

  // ========================================================================
  // Controller states
  // ========================================================================
  typedef enum logic [3:0] {
    NVSP_POWERUP  = 4'h0,
    NVSP_IDLE     = 4'h1,
    NVSP_RD_ADDR  = 4'h2,
    NVSP_RD_DONE  = 4'h3,
    NVSP_WR_PULSE = 4'h4,
    NVSP_WR_GAP   = 4'h5,
    NVSP_PRECHG   = 4'h6,
    NVSP_SLEEP    = 4'h7,
    NVSP_WAKE     = 4'h8
  } nvsp_state_type;

  typedef logic [`NVSP_ADDR_W-1:0] nvsp_addr_type;
  typedef logic [`NVSP_DATA_W-1:0] nvsp_data_type;

endpackage : nvsp_pkg

// ---- nvsp_sram_model.sv ----
// Behavioural model of the clockless 128K x 16 memory port.
// Assumes zero pin delays; released lanes show the inverse of the stored word.
`timescale 1ns/1ps
`default_nettype none

module nvsp_sram_model (
  input wire logic                    ce_n_in,
  input wire logic                    we_n_in,
  input wire logic                    oe_n_in,
  input wire logic                    upper_lane_select_n_in,
  input wire logic                    lower_lane_select_n_in,
  input wire logic                    sleep_request_n_in,
  input wire nvsp_pkg::nvsp_addr_type addr_in,
  input wire nvsp_pkg::nvsp_data_type dq_in,
  output nvsp_pkg::nvsp_data_type     dq_out
);
  import nvsp_pkg::*;
  nvsp_data_type mem [0:2**$bits(nvsp_addr_type)-1];
  logic [14:0]   row;

  // ====================
  // Row is taken when a write or access begins and held through page writes
  always @(negedge we_n_in or negedge ce_n_in) begin
    row = addr_in[16:2];
  end

  // Capture on whichever enable rises first; the other one is still low
  always @(posedge we_n_in or posedge ce_n_in) begin
    if (sleep_request_n_in && (we_n_in ^ ce_n_in)) begin
      if (!lower_lane_select_n_in) mem[{row, addr_in[1:0]}][7:0] = dq_in[7:0];
      if (!upper_lane_select_n_in) mem[{row, addr_in[1:0]}][15:8] = dq_in[15:8];
    end
  end

  // Reads follow the address at once, random or page alike; otherwise float
  always @* begin
    dq_out = ~mem[addr_in];
    if (sleep_request_n_in && !ce_n_in && we_n_in && !oe_n_in) begin
      if (!lower_lane_select_n_in) dq_out[7:0] = mem[addr_in][7:0];
      if (!upper_lane_select_n_in) dq_out[15:8] = mem[addr_in][15:8];
    end
  end
endmodule : nvsp_sram_model

`default_nettype wire

// ---- nvsp_timer_if.sv ----
// Load/expire handshake between the controller and its wait timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface nvsp_timer_if;
  logic        load;    // One-cycle pulse starting a wait
  logic [23:0] count;   // Cycles to wait, sampled with load
  logic        expired; // Level, high while no wait is running

  modport ctrl  (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface : nvsp_timer_if

`default_nettype wire

// ---- nvsp_wait_timer.sv ----
// Down-counter used for every minimum wait of the controller.
// Assumes a load pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module nvsp_wait_timer (
  input  wire logic     clock_in,
  input  wire logic     rst_n_in,
  nvsp_timer_if.timer   tmr
);
  import nvsp_pkg::*;

  typedef struct packed {
    logic [23:0] remain;
  } nvsp_timer_state_type;

  nvsp_timer_state_type cur;
  nvsp_timer_state_type next_cur;

  // ========================================================================
  // Count down to zero; a load restarts the wait
  // ========================================================================
  always_comb begin
    next_cur = cur;
    if (tmr.load) begin
      next_cur.remain = tmr.count;
    end else if (cur.remain != 24'h000000) begin
      next_cur.remain = cur.remain - 24'h000001;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // From the register alone: the load depends on this, so no loop back
  assign tmr.expired = (cur.remain == 24'h000000);

endmodule : nvsp_wait_timer

`default_nettype wire

// ---- tb_nv_async_sram_port.sv ----
// Self-checking bench: host controller against the memory model.
// Assumes the checker file binds itself into the controller.
`timescale 1ns/1ps
`default_nettype none

module tb_nv_async_sram_port;
  import nvsp_pkg::*;
  localparam int unsigned PU_CYC = 20; // Short waits keep the run brief
  localparam int unsigned EX_CYC = 20;
  logic          clock_in = 1'b0;
  logic          rst_n_in = 1'b0;
  logic          req_valid = 1'b0;
  logic          req_write = 1'b0;
  nvsp_addr_type req_addr = '0;
  nvsp_data_type req_wdata = '0;
  logic [1:0]    req_lanes = 2'h0;
  logic          sleep_req = 1'b0;
  logic          ready, rvalid, asleep, ce_n, we_n, oe_n, up_n, lo_n, slp_n, dq_oe;
  nvsp_addr_type addr;
  nvsp_data_type dq_host, dq_dev, dq_bus, rd_word, rdata;
  int            bad_count = 0;
  int            compares = 0;

  always #50 clock_in = ~clock_in;
  assign dq_bus = dq_oe ? dq_host : dq_dev; // Model floats whenever host may drive

  nvsp_host_ctrl #(.POWERUP_CYC(PU_CYC), .SLEEP_EXIT_CYC(EX_CYC)) dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid),
    .req_write_in(req_write), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_lanes_in(req_lanes), .sleep_req_in(sleep_req), .req_ready_out(ready),
    .rdata_valid_out(rvalid), .rdata_out(rd_word), .asleep_out(asleep),
    .chip_enable_n_out(ce_n), .write_enable_n_out(we_n), .output_enable_n_out(oe_n),
    .upper_lane_select_n_out(up_n), .lower_lane_select_n_out(lo_n),
    .sleep_request_n_out(slp_n), .mem_addr_out(addr), .mem_dq_in(dq_bus),
    .mem_dq_out(dq_host), .mem_dq_oe_out(dq_oe));

  nvsp_sram_model mem_model (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .upper_lane_select_n_in(up_n), .lower_lane_select_n_in(lo_n),
    .sleep_request_n_in(slp_n), .addr_in(addr), .dq_in(dq_bus), .dq_out(dq_dev));

  // ====================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until the pins show it began; a row change precharges first
  task automatic do_op(input logic w, input nvsp_addr_type a, input nvsp_data_type d,
                       input logic [1:0] l, output nvsp_data_type q);
    int n;
    n = 0;
    @(posedge clock_in);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= l;
    do begin
      @(negedge clock_in);
      n++;
    end while ((w ? we_n : oe_n) !== 1'b0 && n < 3000);
    @(posedge clock_in);
    req_valid <= 1'b0;
    do begin
      @(negedge clock_in);
      n++;
    end while ((w ? ~we_n : ~rvalid) !== 1'b0 && n < 3000);
    q = rd_word;
    if (n >= 3000) begin
      bad_count++;
      $display("ERROR %0t request never finished", $time);
    end
  endtask : do_op

  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // ====================
  // Scenarios
  task automatic t_powerup;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(negedge clock_in);
      n++;
    end
    chk({31'h0, n >= PU_CYC && n < 5000}, 32'h1);
  endtask : t_powerup

  task automatic t_lanes;
    do_op(1'b1, 17'h00004, 16'hA5C3, 2'h3, rdata);
    do_op(1'b1, 17'h00004, 16'h1200, 2'h2, rdata);
    do_op(1'b1, 17'h00004, 16'h0034, 2'h1, rdata);
    do_op(1'b0, 17'h00004, 16'h0000, 2'h3, rdata);
    chk({16'h0, rdata}, 32'h1234);
    do_op(1'b0, 17'h00004, 16'h0000, 2'h1, rdata);
    chk({16'h0, rdata}, 32'hED34);
    do_op(1'b0, 17'h00004, 16'h0000, 2'h2, rdata);
    chk({16'h0, rdata}, 32'h12CB);
    // Neither lane selected: reads float both bytes, writes change nothing
    do_op(1'b0, 17'h00004, 16'h0000, 2'h0, rdata);
    chk({16'h0, rdata}, 32'hEDCB);
    do_op(1'b1, 17'h00004, 16'hFFFF, 2'h0, rdata);
    do_op(1'b0, 17'h00004, 16'h0000, 2'h3, rdata);
    chk({16'h0, rdata}, 32'h1234);
  endtask : t_lanes

  task automatic t_page;
    for (int i = 0; i < 4; i++) begin
      do_op(1'b1, 17'h00008 + 17'(i), 16'hC0DE + 16'(i), 2'h3, rdata);
    end
    do_op(1'b1, 17'h1F000, 16'h5A5A, 2'h3, rdata);
    for (int i = 3; i >= 0; i--) begin
      do_op(1'b0, 17'h00008 + 17'(i), 16'h0000, 2'h3, rdata);
      chk({16'h0, rdata}, 32'(16'hC0DE + 16'(i)));
    end
    do_op(1'b0, 17'h1F000, 16'h0000, 2'h3, rdata);
    chk({16'h0, rdata}, 32'h5A5A);
  endtask : t_page

  // Sleep straight after a write, then wake and read the word back
  task automatic t_sleep;
    int n;
    n = 0;
    do_op(1'b1, 17'h00100, 16'hBEEF, 2'h3, rdata);
    @(posedge clock_in);
    sleep_req <= 1'b1;
    while (asleep !== 1'b1 && n < 100) begin
      @(negedge clock_in);
      n++;
    end
    chk({29'h0, slp_n, ready, dq_oe}, 32'h0);
    repeat (15) @(posedge clock_in);
    sleep_req <= 1'b0;
    n = 0;
    while (slp_n !== 1'b1 && n < 100) begin
      @(negedge clock_in);
      n++;
    end
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(negedge clock_in);
      n++;
    end
    chk({31'h0, n >= EX_CYC && n < 5000}, 32'h1);
    do_op(1'b0, 17'h00100, 16'h0000, 2'h3, rdata);
    chk({16'h0, rdata}, 32'hBEEF);
  endtask : t_sleep

  // ====================
  // Main sequence
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_powerup();
    t_lanes();
    t_page();
    t_sleep();
    finish_test();
  end

  // Watchdog: the tests need well under 2000 cycles, this allows 30000
  initial begin
    #3000000;
    bad_count++;
    finish_test();
  end
endmodule : tb_nv_async_sram_port

`default_nettype wire
